// ===== core/eeprom_host.sv
`include "eeprom_host_params.svh"

module eeprom_host #(
	parameter int unsigned NONVOLATILE_WRITE_CYC = `NONVOLATILE_WRITE_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire eeprom_host_pkg::op_t cmd_op,
	input  wire logic [7:0]           cmd_addr,
	input  wire logic [7:0]           cmd_len,
	input  wire logic                 chip_select_strap_2,
	input  wire logic                 chip_select_strap_1,
	input  wire logic                 chip_select_strap_0,
	input  wire logic [7:0]           wr_data,
	input  wire logic                 wr_valid,
	output logic                      wr_take,
	output logic [7:0]                rd_data,
	output logic                      rd_valid,
	output logic                      done,
	output logic                      nack_err,
	output logic                      scl_out,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe_n
);

	localparam logic [7:0]  GAP_LAST  = 8'(`BUS_FREE_CYC - 1);
	localparam logic [31:0] POLL_LIMIT = 32'(NONVOLATILE_WRITE_CYC);

	eeprom_host_pkg::state_t state_ff;
	eeprom_host_pkg::state_t nxt_state;
	eeprom_host_pkg::phase_t phase_ff;
	eeprom_host_pkg::phase_t nxt_phase;
	eeprom_host_pkg::op_t    op_ff;
	eeprom_host_pkg::op_t    nxt_op;
	logic [3:0]              bit_cnt_ff;
	logic [3:0]              nxt_bit_cnt;
	logic [7:0]              shreg_ff;
	logic [7:0]              nxt_shreg;
	logic [7:0]              cnt_ff;
	logic [7:0]              nxt_cnt;
	logic [7:0]              addr_ff;
	logic [7:0]              nxt_addr;
	logic [2:0]              strap_ff;
	logic [2:0]              nxt_strap;
	logic                    poll_ff;
	logic                    nxt_poll;
	logic [31:0]             timer_ff;
	logic [31:0]             nxt_timer;
	logic [7:0]              gap_ff;
	logic [7:0]              nxt_gap;
	logic                    ready_ff;
	logic                    nxt_ready;
	logic                    take_ff;
	logic                    nxt_take;
	logic [7:0]              rd_data_ff;
	logic [7:0]              nxt_rd_data;
	logic                    rd_valid_ff;
	logic                    nxt_rd_valid;
	logic                    done_ff;
	logic                    nxt_done;
	logic                    nack_ff;
	logic                    nxt_nack;
	logic                    go_ff;
	logic                    busy_ff;
	logic                    eng_done;
	logic                    eng_bit;

	// array code or serial code, then strap, then direction
	function automatic logic [7:0] dev_word(logic serial, logic [2:0] strap, logic rd);
		return {serial ? `DEV_SERIAL : `DEV_ARRAY, strap, rd};
	endfunction

	// Zero lengths count as one byte; writes clip to one page.
	function automatic logic [7:0] clip_len(logic [7:0] len, logic is_write);
		logic [7:0] r;
		r = (len == 8'h00) ? 8'h01 : len;
		if (is_write && (r > `PAGE_BYTES)) begin
			r = `PAGE_BYTES;
		end
		return r;
	endfunction

	wire [2:0] strap_now  = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
	wire       take_cmd   = cmd_valid && ready_ff;
	wire       is_write   = (cmd_op == eeprom_host_pkg::OP_WRITE);
	wire       is_serial  = (cmd_op == eeprom_host_pkg::OP_SERIAL);
	wire       serial_op  = (op_ff == eeprom_host_pkg::OP_SERIAL);
	wire       write_op   = (op_ff == eeprom_host_pkg::OP_WRITE);
	wire       ack_slot   = (bit_cnt_ff == `ACK_SLOT);
	wire       last_byte  = (cnt_ff == 8'h01);
	wire       got_ack    = !eng_bit;
	wire       gap_end    = (gap_ff == GAP_LAST);
	wire       poll_over  = (timer_ff >= POLL_LIMIT);
	wire [7:0] serial_wa  = `SERIAL_WADDR_TOP | (cmd_addr & `SERIAL_INDEX_MASK);
	wire [7:0] rx_byte    = {shreg_ff[6:0], eng_bit};

	wire in_start = (state_ff == eeprom_host_pkg::S_START);
	wire in_stop  = (state_ff == eeprom_host_pkg::S_STOP);
	wire in_txb   = (state_ff == eeprom_host_pkg::S_TXB);
	wire in_rxb   = (state_ff == eeprom_host_pkg::S_RXB);
	wire in_recov = (state_ff == eeprom_host_pkg::S_RECOV);
	wire need_bit = in_start || in_stop || in_txb || in_rxb || in_recov;
	wire wr_slot  = (in_txb && !ack_slot) || (in_rxb && ack_slot);

	wire recov_start = (bit_cnt_ff == 4'h0) || (bit_cnt_ff == `RECOV_START2);
	wire recov_stop  = (bit_cnt_ff == `RECOV_STOP);

	wire eeprom_host_pkg::bit_kind_t recov_kind =
		recov_start ? eeprom_host_pkg::BK_START :
		recov_stop  ? eeprom_host_pkg::BK_STOP  : eeprom_host_pkg::BK_READ;

	wire eeprom_host_pkg::bit_kind_t eng_kind =
		in_start ? eeprom_host_pkg::BK_START :
		in_stop  ? eeprom_host_pkg::BK_STOP  :
		in_recov ? recov_kind                :
		wr_slot  ? eeprom_host_pkg::BK_WRITE : eeprom_host_pkg::BK_READ;

	wire eng_bit_in = in_txb ? shreg_ff[7] : last_byte;

	i2c_bit_engine u_bit (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.go       (go_ff),
		.kind     (eng_kind),
		.bit_in   (eng_bit_in),
		.sda_in   (sda_in),
		.done     (eng_done),
		.bit_out  (eng_bit),
		.scl_out  (scl_out),
		.sda_out  (sda_out),
		.sda_oe_n (sda_oe_n)
	);

	assign cmd_ready = ready_ff;
	assign wr_take   = take_ff;
	assign rd_data   = rd_data_ff;
	assign rd_valid  = rd_valid_ff;
	assign done      = done_ff;
	assign nack_err  = nack_ff;

	always_comb begin
		nxt_state    = state_ff;
		nxt_phase    = phase_ff;
		nxt_op       = op_ff;
		nxt_bit_cnt  = bit_cnt_ff;
		nxt_shreg    = shreg_ff;
		nxt_cnt      = cnt_ff;
		nxt_addr     = addr_ff;
		nxt_strap    = strap_ff;
		nxt_poll     = poll_ff;
		nxt_timer    = poll_ff ? timer_ff + 32'h1 : timer_ff;
		nxt_gap      = gap_ff;
		nxt_ready    = ready_ff;
		nxt_take     = 1'b0;
		nxt_rd_data  = rd_data_ff;
		nxt_rd_valid = 1'b0;
		nxt_done     = 1'b0;
		nxt_nack     = nack_ff;
		case (state_ff)
			eeprom_host_pkg::S_IDLE: begin
				if (take_cmd) begin
					nxt_ready   = 1'b0;
					nxt_op      = cmd_op;
					nxt_strap   = strap_now;
					nxt_addr    = is_serial ? serial_wa : cmd_addr;
					nxt_cnt     = clip_len(cmd_len, is_write);
					nxt_nack    = 1'b0;
					nxt_poll    = 1'b0;
					nxt_timer   = 32'h0;
					nxt_bit_cnt = 4'h0;
					if (cmd_op == eeprom_host_pkg::OP_RECOVER) begin
						nxt_state = eeprom_host_pkg::S_RECOV;
					end else if (cmd_op == eeprom_host_pkg::OP_READ_CUR) begin
						nxt_state = eeprom_host_pkg::S_START;
						nxt_phase = eeprom_host_pkg::PH_DEVR;
						nxt_shreg = dev_word(1'b0, strap_now, `DIR_READ);
					end else begin
						nxt_state = eeprom_host_pkg::S_START;
						nxt_phase = eeprom_host_pkg::PH_DEVW;
						nxt_shreg = dev_word(is_serial, strap_now, `DIR_WRITE);
					end
				end
			end
			eeprom_host_pkg::S_START: begin
				if (eng_done) begin
					nxt_state   = eeprom_host_pkg::S_TXB;
					nxt_bit_cnt = 4'h0;
				end
			end
			eeprom_host_pkg::S_TXB: begin
				if (eng_done && !ack_slot) begin
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
					nxt_shreg   = {shreg_ff[6:0], 1'b0};
				end else if (eng_done && got_ack) begin
					nxt_bit_cnt = 4'h0;
					case (phase_ff)
						eeprom_host_pkg::PH_DEVW: begin
							nxt_phase = eeprom_host_pkg::PH_WADDR;
							nxt_shreg = addr_ff;
						end
						eeprom_host_pkg::PH_WADDR: begin
							if (write_op) begin
								nxt_phase = eeprom_host_pkg::PH_DATA;
								nxt_state = eeprom_host_pkg::S_LOAD;
							end else begin
								nxt_phase = eeprom_host_pkg::PH_DEVR;
								nxt_shreg = dev_word(serial_op, strap_ff, `DIR_READ);
								nxt_state = eeprom_host_pkg::S_START;
							end
						end
						eeprom_host_pkg::PH_DATA: begin
							if (last_byte) begin
								nxt_poll  = 1'b1;
								nxt_state = eeprom_host_pkg::S_STOP;
							end else begin
								nxt_cnt   = cnt_ff - 8'h01;
								nxt_state = eeprom_host_pkg::S_LOAD;
							end
						end
						eeprom_host_pkg::PH_DEVR: begin
							nxt_state = eeprom_host_pkg::S_RXB;
						end
						default: begin
							nxt_poll  = 1'b0;
							nxt_state = eeprom_host_pkg::S_STOP;
						end
					endcase
				end else if (eng_done) begin
					nxt_bit_cnt = 4'h0;
					nxt_state   = eeprom_host_pkg::S_STOP;
					if (phase_ff != eeprom_host_pkg::PH_POLL) begin
						nxt_nack = 1'b1;
						nxt_poll = 1'b0;
					end
				end
			end
			eeprom_host_pkg::S_LOAD: begin
				if (wr_valid) begin
					nxt_shreg   = wr_data;
					nxt_take    = 1'b1;
					nxt_bit_cnt = 4'h0;
					nxt_state   = eeprom_host_pkg::S_TXB;
				end
			end
			eeprom_host_pkg::S_RXB: begin
				if (eng_done && !ack_slot) begin
					nxt_shreg   = rx_byte;
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == `LAST_DATA_BIT) begin
						nxt_rd_data  = rx_byte;
						nxt_rd_valid = 1'b1;
					end
				end else if (eng_done) begin
					nxt_bit_cnt = 4'h0;
					if (last_byte) begin
						nxt_state = eeprom_host_pkg::S_STOP;
					end else begin
						nxt_cnt = cnt_ff - 8'h01;
					end
				end
			end
			eeprom_host_pkg::S_STOP: begin
				if (eng_done) begin
					if (poll_ff) begin
						nxt_gap   = 8'h00;
						nxt_state = eeprom_host_pkg::S_WAIT;
					end else begin
						nxt_ready = 1'b1;
						nxt_done  = 1'b1;
						nxt_state = eeprom_host_pkg::S_IDLE;
					end
				end
			end
			eeprom_host_pkg::S_WAIT: begin
				nxt_gap = gap_ff + 8'h01;
				if (gap_end && poll_over) begin
					nxt_nack  = 1'b1;
					nxt_poll  = 1'b0;
					nxt_ready = 1'b1;
					nxt_done  = 1'b1;
					nxt_state = eeprom_host_pkg::S_IDLE;
				end else if (gap_end) begin
					nxt_phase = eeprom_host_pkg::PH_POLL;
					nxt_shreg = dev_word(1'b0, strap_ff, `DIR_WRITE);
					nxt_state = eeprom_host_pkg::S_START;
				end
			end
			eeprom_host_pkg::S_RECOV: begin
				if (eng_done && recov_stop) begin
					nxt_bit_cnt = 4'h0;
					nxt_ready   = 1'b1;
					nxt_done    = 1'b1;
					nxt_state   = eeprom_host_pkg::S_IDLE;
				end else if (eng_done) begin
					nxt_bit_cnt = bit_cnt_ff + 4'h1;
				end
			end
			default: begin
				nxt_state = eeprom_host_pkg::S_IDLE;
				nxt_ready = 1'b1;
			end
		endcase
	end

	// A bit request waits for the previous bit to finish, so bits never overlap.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			go_ff   <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			go_ff   <= need_bit && !busy_ff && !go_ff;
			busy_ff <= go_ff || (busy_ff && !eng_done);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff    <= eeprom_host_pkg::S_IDLE;
			phase_ff    <= eeprom_host_pkg::PH_DEVW;
			op_ff       <= eeprom_host_pkg::OP_WRITE;
			bit_cnt_ff  <= 4'h0;
			shreg_ff    <= 8'h00;
			cnt_ff      <= 8'h01;
			addr_ff     <= 8'h00;
			strap_ff    <= 3'h0;
			poll_ff     <= 1'b0;
			timer_ff    <= 32'h0;
			gap_ff      <= 8'h00;
			ready_ff    <= 1'b1;
			take_ff     <= 1'b0;
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
			done_ff     <= 1'b0;
			nack_ff     <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			phase_ff    <= nxt_phase;
			op_ff       <= nxt_op;
			bit_cnt_ff  <= nxt_bit_cnt;
			shreg_ff    <= nxt_shreg;
			cnt_ff      <= nxt_cnt;
			addr_ff     <= nxt_addr;
			strap_ff    <= nxt_strap;
			poll_ff     <= nxt_poll;
			timer_ff    <= nxt_timer;
			gap_ff      <= nxt_gap;
			ready_ff    <= nxt_ready;
			take_ff     <= nxt_take;
			rd_data_ff  <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			done_ff     <= nxt_done;
			nack_ff     <= nxt_nack;
		end
	end

endmodule

// ===== core/eeprom_host_params.svh
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH

`define CLK_PERIOD_NS      10
`define SCL_PERIOD_NS      2500
`define QUARTER_CYC        (((`SCL_PERIOD_NS / 4) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_FREE_NS        1300
`define BUS_FREE_CYC       ((`BUS_FREE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NONVOLATILE_WRITE_TIME_NS  5000000
`define NONVOLATILE_WRITE_CYC      (`NONVOLATILE_WRITE_TIME_NS / `CLK_PERIOD_NS)

`define DEV_ARRAY          4'ha
`define DEV_SERIAL         4'hb
`define DIR_READ           1'h1
`define DIR_WRITE          1'h0
`define SERIAL_WADDR_TOP   8'h80
`define SERIAL_INDEX_MASK  8'h0f
`define PAGE_BYTES         8'h08
`define ACK_SLOT           4'h8
`define LAST_DATA_BIT      4'h7
`define RECOV_START2       4'ha
`define RECOV_STOP         4'hb

`endif

// ===== core/eeprom_host_pkg.sv
package eeprom_host_pkg;

	typedef enum logic [1:0] {
		BK_START = 2'h0,
		BK_STOP  = 2'h1,
		BK_WRITE = 2'h2,
		BK_READ  = 2'h3
	} bit_kind_t;

	typedef enum logic [2:0] {
		OP_WRITE     = 3'h0,
		OP_READ_CUR  = 3'h1,
		OP_READ_RAND = 3'h2,
		OP_SERIAL    = 3'h3,
		OP_RECOVER   = 3'h4
	} op_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_START = 4'h1,
		S_TXB   = 4'h3,
		S_RXB   = 4'h2,
		S_STOP  = 4'h6,
		S_WAIT  = 4'h7,
		S_LOAD  = 4'h5,
		S_RECOV = 4'h4
	} state_t;

	typedef enum logic [2:0] {
		PH_DEVW  = 3'h0,
		PH_WADDR = 3'h1,
		PH_DATA  = 3'h3,
		PH_DEVR  = 3'h2,
		PH_POLL  = 3'h6
	} phase_t;

endpackage

// ===== core/i2c_bit_engine.sv
`include "eeprom_host_params.svh"

module i2c_bit_engine (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       go,
	input  wire eeprom_host_pkg::bit_kind_t kind,
	input  wire logic                       bit_in,
	input  wire logic                       sda_in,
	output logic                            done,
	output logic                            bit_out,
	output logic                            scl_out,
	output logic                            sda_out,
	output logic                            sda_oe_n
);

	localparam logic [7:0] QLAST = 8'(`QUARTER_CYC - 1);

	logic [7:0]                 div_ff;
	logic [1:0]                 q_ff;
	logic                       active_ff;
	eeprom_host_pkg::bit_kind_t kind_ff;
	logic                       bit_ff;
	logic                       sda_meta_ff;
	logic                       sda_sync_ff;
	logic                       done_ff;
	logic                       bit_out_ff;
	logic                       scl_ff;
	logic                       oe_n_ff;
	logic                       zero_ff;

	// Returns {scl, oe_n}. Quarter 0 only lowers the clock, quarter 1 moves data.
	function automatic logic [1:0] drive(eeprom_host_pkg::bit_kind_t k, logic [1:0] q,
		logic b, logic cur);
		logic [1:0] r;
		r = {1'b0, cur};
		if (q != 2'h0) begin
			case (k)
				eeprom_host_pkg::BK_START: r = {q != 2'h1, q != 2'h3};
				eeprom_host_pkg::BK_STOP:  r = {q != 2'h1, q == 2'h3};
				eeprom_host_pkg::BK_WRITE: r = {q != 2'h1, b};
				default:                   r = {q != 2'h1, 1'b1};
			endcase
		end
		return r;
	endfunction

	wire       q_end = active_ff && (div_ff == QLAST);
	wire       last  = q_end && (q_ff == 2'h3);
	wire [1:0] drv   = drive(kind_ff, q_ff, bit_ff, oe_n_ff);

	assign done     = done_ff;
	assign bit_out  = bit_out_ff;
	assign scl_out  = scl_ff;
	assign sda_out  = zero_ff;
	assign sda_oe_n = oe_n_ff;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_ff      <= 8'h00;
			q_ff        <= 2'h0;
			active_ff   <= 1'b0;
			kind_ff     <= eeprom_host_pkg::BK_READ;
			bit_ff      <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
			done_ff     <= 1'b0;
			bit_out_ff  <= 1'b1;
			scl_ff      <= 1'b1;
			oe_n_ff     <= 1'b1;
			zero_ff     <= 1'b0;
		end else begin
			sda_meta_ff <= sda_in;
			sda_sync_ff <= sda_meta_ff;
			done_ff     <= last;
			zero_ff     <= 1'b0;
			if (go && !active_ff) begin
				active_ff <= 1'b1;
				q_ff      <= 2'h0;
				div_ff    <= 8'h00;
				kind_ff   <= kind;
				bit_ff    <= bit_in;
			end else if (active_ff) begin
				div_ff <= q_end ? 8'h00 : div_ff + 8'h01;
				if (q_end) begin
					q_ff <= q_ff + 2'h1;
				end
				if (last) begin
					active_ff <= 1'b0;
				end
			end
			if (last) begin
				bit_out_ff <= sda_sync_ff;
			end
			if (active_ff) begin
				scl_ff  <= drv[1];
				oe_n_ff <= drv[0];
			end
		end
	end

endmodule

// ===== test/eeprom_host_checker.sv
module eeprom_host_checker #(
	parameter int unsigned NONVOLATILE_WRITE_CYC = 500000
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic wr_valid,
	input wire logic wr_take,
	input wire logic rd_valid,
	input wire logic done,
	input wire logic nack_err,
	input wire logic scl_out,
	input wire logic sda_out,
	input wire logic sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_sda_setup_hold: assert property (($rose(scl_out) || $fell(scl_out)) |-> $stable(sda_oe_n))
		else $error("data line moved on a bus clock edge");
	a_start_first: assert property (cmd_valid && cmd_ready |-> ##[1:600] (scl_out && $fell(sda_oe_n)))
		else $error("no start condition after a command was taken");
	a_open_drain: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_idle_released: assert property (cmd_ready |-> scl_out && sda_oe_n)
		else $error("bus not released while idle");
	a_done_ready: assert property (done |-> $rose(cmd_ready))
		else $error("done without return to idle");
	a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready && !nack_err)
		else $error("command take did not start a transfer");
	a_wr_take_cause: assert property (wr_take |-> $past(wr_valid) && !cmd_ready ##1 !wr_take)
		else $error("write byte taken without offer");
	a_rd_pulse: assert property (rd_valid |-> !cmd_ready ##1 !rd_valid)
		else $error("read byte reported outside a command");
	a_scl_high_min: assert property ($rose(scl_out) |-> scl_out[*8])
		else $error("bus clock high phase too short");

	c_nack: cover property (done && nack_err);
	c_write: cover property (wr_take);
	c_read: cover property (rd_valid);
endmodule

bind eeprom_host eeprom_host_checker #(
	.NONVOLATILE_WRITE_CYC(NONVOLATILE_WRITE_CYC)
) chk (
	.clk(clk),
	.sys_rst(sys_rst),
	.cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready),
	.wr_valid(wr_valid),
	.wr_take(wr_take),
	.rd_valid(rd_valid),
	.done(done),
	.nack_err(nack_err),
	.scl_out(scl_out),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n)
);

// ===== test/eeprom_host_tb.sv
module eeprom_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk, sys_rst, cmd_valid, cmd_ready;
	eeprom_host_pkg::op_t cmd_op;
	logic [7:0]           cmd_addr, cmd_len, wr_data, rd_data;
	logic [2:0]           strap;
	logic                 wr_valid, wr_take, rd_valid, done, nack_err;
	logic                 scl_out, sda_out, sda_oe_n, dev_oe_n;
	wire                  sda;
	logic [7:0]           wbuf [8];
	logic [7:0]           rq [$];
	int                   wi, wn, num_errors, compares, cycles;

	// Open-drain wire with a pull-up.
	assign sda = (sda_oe_n ? 1'b1 : sda_out) & dev_oe_n;

	eeprom_host #(.NONVOLATILE_WRITE_CYC(20000)) dut (
		.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.chip_select_strap_2(strap[2]), .chip_select_strap_1(strap[1]),
		.chip_select_strap_0(strap[0]), .wr_data(wr_data), .wr_valid(wr_valid),
		.wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
		.nack_err(nack_err), .scl_out(scl_out), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n)
	);
	eeprom_model #(.STRAP(3'h5), .BUSY_CYC(3000)) dev (
		.clk(clk), .scl(scl_out), .sda(sda), .sda_oe_n(dev_oe_n)
	);

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rd_valid) rq.push_back(rd_data);
		if (wr_take) wi <= wi + 1;
		wr_valid <= wi < wn;
		wr_data <= wbuf[wi[2:0]];
		if (cycles == 95000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic run(eeprom_host_pkg::op_t op, logic [7:0] a, logic [7:0] n);
		rq.delete();
		wi = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_len <= n;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (int k = 0; k < 40000 && done !== 1'b1; k++) @(posedge clk);
		chk8("cmd_done", 8'h01, {7'h0, done});
		if (done !== 1'b1) end_of_test();
	endtask

	task automatic t_write();
		wbuf = '{8'ha1, 8'ha2, 8'ha3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		wn = 3;
		run(eeprom_host_pkg::OP_WRITE, 8'h0f, 8'h03);
		wn = 0;
		chk8("write_nack", 8'h00, {7'h0, nack_err});
		chk8("write_bytes", 8'h03, 8'(wi));
		chk8("poll_busy", 8'h00, {7'h0, dev.busy != 0});
		$display("write test done");
	endtask

	task automatic t_reads();
		run(eeprom_host_pkg::OP_READ_RAND, 8'h08, 8'h02);
		chk8("rand_count", 8'h02, 8'(rq.size()));
		chk8("rand_byte0", 8'ha2, rq[0]);
		chk8("rand_byte1", 8'ha3, rq[1]);
		run(eeprom_host_pkg::OP_READ_CUR, 8'h00, 8'h01);
		chk8("cur_byte", 8'hf5, rq[0]);
		chk8("cur_count", 8'h01, 8'(rq.size()));
		$display("read test done");
	endtask

	task automatic t_serial();
		run(eeprom_host_pkg::OP_SERIAL, 8'h0f, 8'h02);
		chk8("serial_last", 8'h3f, rq[0]);
		chk8("serial_wrap", 8'h30, rq[1]);
		chk8("serial_nack", 8'h00, {7'h0, nack_err});
		$display("serial test done");
	endtask

	task automatic t_strap();
		strap <= 3'h2;
		run(eeprom_host_pkg::OP_READ_CUR, 8'h00, 8'h01);
		chk8("strap_nack", 8'h01, {7'h0, nack_err});
		chk8("strap_count", 8'h00, 8'(rq.size()));
		strap <= 3'h5;
		$display("strap test done");
	endtask

	task automatic t_recover();
		run(eeprom_host_pkg::OP_RECOVER, 8'h00, 8'h00);
		chk8("recover_nack", 8'h00, {7'h0, nack_err});
		run(eeprom_host_pkg::OP_READ_CUR, 8'h00, 8'h01);
		chk8("after_recover", 8'h7e, rq[0]);
		$display("recover test done");
	endtask

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = eeprom_host_pkg::OP_WRITE;
		cmd_addr = 8'h00;
		cmd_len = 8'h00;
		strap = 3'h5;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		{wi, wn, num_errors, compares, cycles} = '0;
		repeat (12) @(posedge clk);
		chk8("reset_pins", 8'h0e, {4'h0, cmd_ready, scl_out, sda_oe_n, sda_out});
		sys_rst <= 1'b0;
		t_write();
		t_reads();
		t_serial();
		t_strap();
		t_recover();
		end_of_test();
	end
endmodule

// ===== test/eeprom_model.sv
module eeprom_model #(
	parameter logic [2:0] STRAP         = 3'h5,
	parameter int         BUSY_CYC      = 2000,
	parameter logic       WRITE_PROTECT = 1'b0
) (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sn [16];
	logic [7:0] sr, ptr, dout;
	logic [3:0] bitc;
	logic [2:0] ph;
	logic       scl_q, sda_q, ser, wrote;
	int         busy;

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'hff - 8'(i);
			if (i < 16) sn[i] = 8'h30 + 8'(i);
		end
		{scl_q, sda_q, ser, wrote, ph, bitc, sr, ptr} = '0;
		busy = 0;
		sda_oe_n = 1'b1;
	end
	// Serial data only behind a 10 prefix, so a wrong word address shows.
	assign dout = ser ? ((ptr[7:6] == 2'h2) ? sn[ptr[3:0]] : 8'h00) : mem[ptr];

	// Sampling on the system clock keeps the model free of edge races.
	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (busy > 0) busy <= busy - 1;
		if (scl && scl_q && sda_q && !sda) begin
			ph <= 3'h1;
			bitc <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (scl && scl_q && !sda_q && sda) begin
			if (wrote) busy <= BUSY_CYC;
			wrote <= 1'b0;
			ph <= 3'h0;
			sda_oe_n <= 1'b1;
		end else if (ph != 3'h0 && scl && !scl_q) begin
			bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
			if (bitc < 4'h8) sr <= {sr[6:0], sda};
			else if (ph == 3'h4 && sda) ph <= 3'h0;
		end else if (ph != 3'h0 && !scl && scl_q) begin
			if (bitc == 4'h8 && ph == 3'h4) begin
				sda_oe_n <= 1'b1;
				ptr <= ser ? {ptr[7:4], ptr[3:0] + 4'h1} : ptr + 8'h1;
			end else if (bitc == 4'h8) begin
				sda_oe_n <= 1'b0;
				if (ph == 3'h1) begin
					if (sr[7:5] == 3'h5 && sr[3:1] == STRAP && busy == 0) begin
						ser <= sr[4];
						ph <= sr[0] ? 3'h4 : 3'h2;
					end else begin
						sda_oe_n <= 1'b1;
						ph <= 3'h0;
					end
				end
				if (ph == 3'h2) begin
					ptr <= sr;
					ph <= 3'h3;
				end
				if (ph == 3'h3) begin
					if (!ser && !WRITE_PROTECT) mem[ptr] <= sr;
					wrote <= !ser;
					ptr <= {ptr[7:3], ptr[2:0] + 3'h1};
				end
			end else if (ph == 3'h4) sda_oe_n <= dout[3'h7 - bitc[2:0]];
			else sda_oe_n <= 1'b1;
		end
	end
endmodule
